//--- hw/ext_int_pkg.sv
// Package for the dual external interrupt latch block.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit register layout.
package ext_int_pkg;
	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_EXT_B = 8'h1C; // ext_int_b_status_control
	localparam logic [7:0] IDX_EXT_A = 8'h1E; // ext_int_a_status_control
	localparam logic [7:0] IDX_BRK_CTRL = 8'h20; // break_flag_control_reg
	localparam logic [7:0] IDX_IRQ_STAT = 8'h21; // sticky event status
	localparam logic [7:0] IDX_IRQ_MASK = 8'h22; // event mask
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int PEND_BIT = 3;
	localparam int ACK_BIT = 2;
	localparam int MASK_BIT = 1;
	localparam int SENSE_BIT = 0;
	localparam int PULLUP_BIT = 6;
	localparam int PERMIT_BIT = 0;
	localparam int EVT_A_BIT = 0;
	localparam int EVT_B_BIT = 1;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] EVT_RST = 2'h0;
	localparam logic PIN_IDLE = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;

	// Register write carried from the bus port to the register file
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} bus_wr_t;

	// Byte address of a register index
	function automatic logic [7:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx[5:0], 2'b00};
	endfunction : byte_addr

	// True for an address that some register answers
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == byte_addr(IDX_EXT_A)) ||
			(a == byte_addr(IDX_EXT_B)) ||
			(a == byte_addr(IDX_BRK_CTRL)) ||
			(a == byte_addr(IDX_IRQ_STAT)) ||
			(a == byte_addr(IDX_IRQ_MASK));
	endfunction : addr_mapped
endpackage : ext_int_pkg

//--- hw/ext_int_channel.sv
// One external request channel: edge detect, level sense and latch.
// Assumes the pin is already synchronous to the clock; idle level high.
`timescale 1ns/1ps
`default_nettype none
module ext_int_channel (
	input wire logic sys_clk_i, // Bus clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic req_pin_n_i, // Active-low request pin
	input wire logic sense_i, // 1: edge and level, 0: edge only
	input wire logic clear_i, // Qualified acknowledge pulse
	output logic latch_o, // Pending latch
	output logic event_o // Pulse when latch newly sets
);
	import ext_int_pkg::*;

	logic pin_prev_ff;
	logic set_req;

	// ----------------------------------------------------------------
	// Request detection
	// ----------------------------------------------------------------
	// Falling edge always; a held low level only in level mode
	assign set_req = (pin_prev_ff & ~req_pin_n_i) | (sense_i & ~req_pin_n_i);

	// Previous pin level, idle high so reset itself makes no edge
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_prev_ff <= PIN_IDLE;
		end else begin
			pin_prev_ff <= req_pin_n_i;
		end
	end

	// Latch: only the pin sets it, so break exit restores nothing
	// A request in the clearing cycle wins over the clear
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			latch_o <= 1'b0;
		end else if (set_req) begin
			latch_o <= 1'b1;
		end else if (clear_i) begin
			latch_o <= 1'b0;
		end
	end

	// New-pending pulse feeds the sticky event status
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			event_o <= 1'b0;
		end else begin
			event_o <= set_req & ~latch_o;
		end
	end
endmodule : ext_int_channel
`default_nettype wire

//--- hw/axil_reg_port.sv
// AXI4-Lite slave port: turns bus transfers into register accesses.
// Assumes one write and one read in flight; read data decoded outside.
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port #(
	parameter int ADDR_W = 8 // Byte address width
) (
	input wire logic sys_clk_i, // Bus clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [ADDR_W-1:0] awaddr_i, // Write address
	input wire logic awvalid_i, // Write address valid
	output logic awready_o, // Write address ready
	input wire logic [31:0] wdata_i, // Write data
	input wire logic [3:0] wstrb_i, // Write byte strobes
	input wire logic wvalid_i, // Write data valid
	output logic wready_o, // Write data ready
	output logic [1:0] bresp_o, // Write response
	output logic bvalid_o, // Write response valid
	input wire logic bready_i, // Write response ready
	input wire logic arvalid_i, // Read address valid
	output logic arready_o, // Read address ready
	input wire logic [31:0] rd_data_i, // Decoded data of araddr
	input wire logic rd_ok_i, // araddr is mapped
	output logic [31:0] rdata_o, // Read data
	output logic [1:0] rresp_o, // Read response
	output logic rvalid_o, // Read data valid
	input wire logic rready_i, // Read data ready
	output ext_int_pkg::bus_wr_t wr_o // Register write, one cycle
);
	import ext_int_pkg::*;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rd_state_t;

	rd_state_t rd_state_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic commit;

	// Only an 8-bit byte address is decoded; refused at elaboration
	if (ADDR_W != 8) begin : g_addr_w_check
		$error("axil_reg_port: ADDR_W must be 8");
	end

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	// Waits for the previous response so one write is in flight
	assign commit = aw_held_ff & w_held_ff & ~bvalid_o & ~wr_o.en;

	// Address and data are taken in either order and held
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			aw_held_ff <= 1'b0;
			awready_o <= 1'b1;
			aw_addr_ff <= REG_RST;
		end else if (awvalid_i && awready_o) begin
			aw_held_ff <= 1'b1;
			awready_o <= 1'b0;
			aw_addr_ff <= awaddr_i[7:0];
		end else if (commit) begin
			aw_held_ff <= 1'b0;
			awready_o <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			w_held_ff <= 1'b0;
			wready_o <= 1'b1;
			w_data_ff <= DATA_RST;
			w_strb_ff <= 4'h0;
		end else if (wvalid_i && wready_o) begin
			w_held_ff <= 1'b1;
			wready_o <= 1'b0;
			w_data_ff <= wdata_i;
			w_strb_ff <= wstrb_i;
		end else if (commit) begin
			w_held_ff <= 1'b0;
			wready_o <= 1'b1;
		end
	end

	// Register update and response rise on the same edge
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_o <= '0;
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else begin
			wr_o.en <= commit;
			wr_o.addr <= aw_addr_ff;
			wr_o.data <= w_data_ff;
			wr_o.strb <= w_strb_ff;
			if (wr_o.en) begin
				bvalid_o <= 1'b1;
				bresp_o <= addr_mapped(wr_o.addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	// Data is sampled at the address handshake; reads have no side effect
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_state_ff <= RD_IDLE;
			arready_o <= 1'b1;
			rvalid_o <= 1'b0;
			rdata_o <= DATA_RST;
			rresp_o <= RESP_OKAY;
		end else begin
			case (rd_state_ff)
				RD_IDLE: begin
					if (arvalid_i) begin
						rd_state_ff <= RD_RESP;
						arready_o <= 1'b0;
						rvalid_o <= 1'b1;
						rdata_o <= rd_data_i;
						rresp_o <= rd_ok_i ? RESP_OKAY : RESP_SLVERR;
					end
				end
				RD_RESP: begin
					if (rready_i) begin
						rd_state_ff <= RD_IDLE;
						arready_o <= 1'b1;
						rvalid_o <= 1'b0;
					end
				end
				default: begin
					rd_state_ff <= RD_IDLE;
				end
			endcase
		end
	end
endmodule : axil_reg_port
`default_nettype wire

//--- hw/dual_ext_int_latch.sv
// Dual external interrupt latch with AXI4-Lite register access.
// Assumes pins synchronous to sys_clk_i and a break-state level input.
//
// What this block does
// - Permitted acknowledge clears latch during break
// - Latch cleared in break stays cleared
// - Without permit, break acknowledge changes nothing
// - Per-channel registers at indices 1E, 1C
// - Read-only pending flag shows latch state
// - Acknowledge write of one clears latch
// - Mask bit one blocks CPU request
// - Sense bit selects edge or edge-level
// - Second channel bit disables pin pullup
`timescale 1ns/1ps
`default_nettype none
module dual_ext_int_latch (
	input wire logic sys_clk_i, // Bus clock, 125 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic ext_request_a_pin_n_i, // Channel A request, low
	input wire logic ext_request_b_pin_n_i, // Channel B request, low
	input wire logic break_state_i, // Processor in break state
	output logic irq_req_a_o, // Channel A request to CPU
	output logic irq_req_b_o, // Channel B request to CPU
	output logic pullup_b_disable_o, // Channel B pullup off
	output logic irq_o, // Summary event interrupt
	input wire logic [7:0] s_axi_awaddr_i, // AXI write address
	input wire logic s_axi_awvalid_i, // AXI write address valid
	output logic s_axi_awready_o, // AXI write address ready
	input wire logic [31:0] s_axi_wdata_i, // AXI write data
	input wire logic [3:0] s_axi_wstrb_i, // AXI write strobes
	input wire logic s_axi_wvalid_i, // AXI write data valid
	output logic s_axi_wready_o, // AXI write data ready
	output logic [1:0] s_axi_bresp_o, // AXI write response
	output logic s_axi_bvalid_o, // AXI write response valid
	input wire logic s_axi_bready_i, // AXI write response ready
	input wire logic [7:0] s_axi_araddr_i, // AXI read address
	input wire logic s_axi_arvalid_i, // AXI read address valid
	output logic s_axi_arready_o, // AXI read address ready
	output logic [31:0] s_axi_rdata_o, // AXI read data
	output logic [1:0] s_axi_rresp_o, // AXI read response
	output logic s_axi_rvalid_o, // AXI read data valid
	input wire logic s_axi_rready_i // AXI read data ready
);
	import ext_int_pkg::*;

	bus_wr_t wr;
	logic [31:0] rd_data;
	logic wr_a;
	logic wr_b;
	logic ack_ok;
	logic clr_a;
	logic clr_b;
	logic latch_a;
	logic latch_b;
	logic evt_a;
	logic evt_b;
	logic mask_a_ff;
	logic mask_b_ff;
	logic sense_a_ff;
	logic sense_b_ff;
	logic permit_ff;
	logic [1:0] evt_stat_ff;
	logic [1:0] evt_mask_ff;

	// ----------------------------------------------------------------
	// Bus port and channels
	// ----------------------------------------------------------------
	axil_reg_port #(
		.ADDR_W(8)
	) u_port (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.awaddr_i(s_axi_awaddr_i),
		.awvalid_i(s_axi_awvalid_i),
		.awready_o(s_axi_awready_o),
		.wdata_i(s_axi_wdata_i),
		.wstrb_i(s_axi_wstrb_i),
		.wvalid_i(s_axi_wvalid_i),
		.wready_o(s_axi_wready_o),
		.bresp_o(s_axi_bresp_o),
		.bvalid_o(s_axi_bvalid_o),
		.bready_i(s_axi_bready_i),
		.arvalid_i(s_axi_arvalid_i),
		.arready_o(s_axi_arready_o),
		.rd_data_i(rd_data),
		.rd_ok_i(addr_mapped(s_axi_araddr_i)),
		.rdata_o(s_axi_rdata_o),
		.rresp_o(s_axi_rresp_o),
		.rvalid_o(s_axi_rvalid_o),
		.rready_i(s_axi_rready_i),
		.wr_o(wr)
	);

	ext_int_channel u_chan_a (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.req_pin_n_i(ext_request_a_pin_n_i),
		.sense_i(sense_a_ff),
		.clear_i(clr_a),
		.latch_o(latch_a),
		.event_o(evt_a)
	);

	ext_int_channel u_chan_b (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.req_pin_n_i(ext_request_b_pin_n_i),
		.sense_i(sense_b_ff),
		.clear_i(clr_b),
		.latch_o(latch_b),
		.event_o(evt_b)
	);

	// ----------------------------------------------------------------
	// Write decode and acknowledge qualification
	// ----------------------------------------------------------------
	// Only byte lane 0 carries the 8-bit registers
	assign wr_a = wr.en && wr.strb[0] && wr.addr == byte_addr(IDX_EXT_A);
	assign wr_b = wr.en && wr.strb[0] && wr.addr == byte_addr(IDX_EXT_B);
	// In break, acknowledge only acts when permitted
	assign ack_ok = ~break_state_i | permit_ff;
	assign clr_a = wr_a & wr.data[ACK_BIT] & ack_ok;
	assign clr_b = wr_b & wr.data[ACK_BIT] & ack_ok;

	// Channel control bits; acknowledge is not stored
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mask_a_ff <= 1'b0;
			sense_a_ff <= 1'b0;
		end else if (wr_a) begin
			mask_a_ff <= wr.data[MASK_BIT];
			sense_a_ff <= wr.data[SENSE_BIT];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mask_b_ff <= 1'b0;
			sense_b_ff <= 1'b0;
			pullup_b_disable_o <= 1'b0;
		end else if (wr_b) begin
			mask_b_ff <= wr.data[MASK_BIT];
			sense_b_ff <= wr.data[SENSE_BIT];
			pullup_b_disable_o <= wr.data[PULLUP_BIT];
		end
	end

	// Break permit and event mask registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			permit_ff <= 1'b0;
			evt_mask_ff <= EVT_RST;
		end else if (wr.en && wr.strb[0]) begin
			if (wr.addr == byte_addr(IDX_BRK_CTRL)) begin
				permit_ff <= wr.data[PERMIT_BIT];
			end
			if (wr.addr == byte_addr(IDX_IRQ_MASK)) begin
				evt_mask_ff <= wr.data[1:0];
			end
		end
	end

	// Sticky events: a new event beats a write-one clear
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			evt_stat_ff <= EVT_RST;
		end else begin
			if (wr.en && wr.strb[0] && wr.addr == byte_addr(IDX_IRQ_STAT)) begin
				evt_stat_ff <= (evt_stat_ff & ~wr.data[1:0]) | {evt_b, evt_a};
			end else begin
				evt_stat_ff <= evt_stat_ff | {evt_b, evt_a};
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// CPU requests follow the latch gated by the mask
	// One cycle of lag keeps every output straight from a flop
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_req_a_o <= 1'b0;
			irq_req_b_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			irq_req_a_o <= latch_a & ~mask_a_ff;
			irq_req_b_o <= latch_b & ~mask_b_ff;
			irq_o <= |(evt_stat_ff & evt_mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	// Acknowledge and unused bits read zero
	always_comb begin
		rd_data = DATA_RST;
		if (s_axi_araddr_i == byte_addr(IDX_EXT_A)) begin
			rd_data[PEND_BIT] = latch_a;
			rd_data[MASK_BIT] = mask_a_ff;
			rd_data[SENSE_BIT] = sense_a_ff;
		end else if (s_axi_araddr_i == byte_addr(IDX_EXT_B)) begin
			rd_data[PULLUP_BIT] = pullup_b_disable_o;
			rd_data[PEND_BIT] = latch_b;
			rd_data[MASK_BIT] = mask_b_ff;
			rd_data[SENSE_BIT] = sense_b_ff;
		end else if (s_axi_araddr_i == byte_addr(IDX_BRK_CTRL)) begin
			rd_data[PERMIT_BIT] = permit_ff;
		end else if (s_axi_araddr_i == byte_addr(IDX_IRQ_STAT)) begin
			rd_data[1:0] = evt_stat_ff;
		end else if (s_axi_araddr_i == byte_addr(IDX_IRQ_MASK)) begin
			rd_data[1:0] = evt_mask_ff;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_break_ack_clears: assert property (
		(wr_a && wr.data[ACK_BIT] && break_state_i && permit_ff &&
			!sense_a_ff && ext_request_a_pin_n_i &&
			$past(ext_request_a_pin_n_i)) |=> !latch_a)
		else $error("permitted break acknowledge left latch set");

	a_break_exit_clear: assert property (
		($fell(break_state_i) && !latch_a && !sense_a_ff &&
			ext_request_a_pin_n_i && $past(ext_request_a_pin_n_i))
			|=> !latch_a)
		else $error("latch came back on break exit");

	a_break_ack_blocked: assert property (
		(wr_a && wr.data[ACK_BIT] && break_state_i && !permit_ff &&
			latch_a) |=> latch_a)
		else $error("break acknowledge cleared latch without permit");

	a_pend_readback: assert property (
		(s_axi_arvalid_i && s_axi_arready_o &&
			s_axi_araddr_i == byte_addr(IDX_EXT_A)) |=>
			(s_axi_rdata_o[PEND_BIT] == $past(latch_a) &&
			s_axi_rdata_o[ACK_BIT] == 1'b0 && s_axi_rdata_o[7:4] == 4'h0))
		else $error("channel A register read back wrong");

	a_mask_blocks_req: assert property (
		mask_a_ff |=> !irq_req_a_o)
		else $error("masked channel A raised a request");

	a_level_relatch: assert property (
		(sense_b_ff && !ext_request_b_pin_n_i) |=> latch_b [*1] ##1
			irq_req_b_o == !$past(mask_b_ff))
		else $error("level mode did not hold the request");

	a_edge_only: assert property (
		(!sense_b_ff && !latch_b && !ext_request_b_pin_n_i &&
			!$past(ext_request_b_pin_n_i)) |=> !latch_b)
		else $error("edge mode latched a steady low level");

	a_pullup_write: assert property (
		wr_b |=> pullup_b_disable_o == $past(wr.data[PULLUP_BIT]))
		else $error("pullup disable bit not stored");

	a_unmasked_req: assert property (
		(latch_a && !mask_a_ff) |=> irq_req_a_o)
		else $error("unmasked pending latch gave no request");

	a_irq_summary: assert property (
		(evt_stat_ff & evt_mask_ff) != 2'h0 |=> irq_o)
		else $error("summary interrupt missing");

	// Further checks on acknowledge, readback, CPU requests and event status
	a_ack_clears_b: assert property (
		(clr_b && !sense_b_ff && ext_request_b_pin_n_i) |=> !latch_b)
		else $error("acknowledge left channel B latch set");

	a_read_b_fields: assert property (
		(s_axi_arvalid_i && s_axi_arready_o &&
			s_axi_araddr_i == byte_addr(IDX_EXT_B)) |=>
			(s_axi_rdata_o[PEND_BIT] == $past(latch_b) &&
			s_axi_rdata_o[PULLUP_BIT] == $past(pullup_b_disable_o) &&
			s_axi_rdata_o[ACK_BIT] == 1'b0 && s_axi_rdata_o[7] == 1'b0))
		else $error("channel B register read back wrong");

	a_unmasked_req_b: assert property (
		(latch_b && !mask_b_ff) |=> irq_req_b_o)
		else $error("unmasked channel B latch gave no request");

	a_idle_no_req: assert property (
		!latch_a |=> !irq_req_a_o)
		else $error("channel A request without a pending latch");

	a_event_recorded: assert property (
		evt_a |=> evt_stat_ff[EVT_A_BIT])
		else $error("new channel A event not recorded");

	a_event_sticky: assert property (
		(evt_stat_ff[EVT_A_BIT] && !(wr.en && wr.strb[0] &&
			wr.addr == byte_addr(IDX_IRQ_STAT) && wr.data[EVT_A_BIT]))
			|=> evt_stat_ff[EVT_A_BIT])
		else $error("channel A event bit lost without a clear");
endmodule : dual_ext_int_latch
`default_nettype wire

//--- test/ext_pin_partner.sv
// Model of the external parties that pull the two request pins low.
// Assumes the bench commands each pin just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_partner (
	input wire logic sys_clk_i, // Bus clock
	input wire logic [1:0] drive_low_i, // 1: party pulls pin low
	input wire logic pullup_b_disable_i, // Channel B pullup off
	output logic pin_a_n_o, // Channel A pin level
	output logic pin_b_n_o // Channel B pin level
);
	// ------------------------------------------------------------------
	// Released pin levels
	// ------------------------------------------------------------------
	logic decayed_ff;

	// Line left without its pullup drifts low one clock later
	always_ff @(posedge sys_clk_i) begin
		decayed_ff <= pullup_b_disable_i;
	end

	// Channel A has a fixed pullup; channel B only while enabled
	assign pin_a_n_o = drive_low_i[0] ? 1'b0 : 1'b1;
	assign pin_b_n_o = drive_low_i[1] ? 1'b0 : ~decayed_ff;
endmodule : ext_pin_partner
`default_nettype wire

//--- test/dual_ext_int_latch_tb_top.sv
// Testbench for the dual external interrupt latch, driven over AXI4-Lite.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dual_ext_int_latch_tb_top;
	import ext_int_pkg::*;
	// ------------------------------------------------------------------
	// Byte addresses, four times each register index
	// ------------------------------------------------------------------
	localparam logic [7:0] AD_B = 8'h70;
	localparam logic [7:0] AD_A = 8'h78;
	localparam logic [7:0] AD_BRK = 8'h80;
	localparam logic [7:0] AD_EVS = 8'h84;
	localparam logic [7:0] AD_EVM = 8'h88;
	localparam logic [7:0] AD_HOLE = 8'h74;

	logic sys_clk_i = 1'b0;
	logic rst_i, brk, awvalid, wvalid, bready, arvalid, rready;
	logic [1:0] drv_low, bresp, rresp, rsp;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0] wstrb;
	logic pin_a_n, pin_b_n, irq_a, irq_b, pu_dis, irq, awready, wready;
	logic bvalid, arready, rvalid;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #4 sys_clk_i = ~sys_clk_i;

	dual_ext_int_latch u_dual_ext_int_latch (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .ext_request_a_pin_n_i(pin_a_n),
		.ext_request_b_pin_n_i(pin_b_n), .break_state_i(brk),
		.irq_req_a_o(irq_a), .irq_req_b_o(irq_b),
		.pullup_b_disable_o(pu_dis), .irq_o(irq),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));

	ext_pin_partner u_ext_pin_partner (.sys_clk_i(sys_clk_i),
		.drive_low_i(drv_low), .pullup_b_disable_i(pu_dis),
		.pin_a_n_o(pin_a_n), .pin_b_n_o(pin_b_n));

	// ------------------------------------------------------------------
	// Comparison and closing tasks
	// ------------------------------------------------------------------
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_resp(input string nm, input logic [1:0] e,
		input logic [1:0] g);
		chk_word(nm, {30'h0, e}, {30'h0, g});
	endtask : chk_resp

	// Samples at the falling edge so registered outputs have settled
	task automatic chk_bit(input string nm, input int i, input logic e);
		logic [3:0] outs;
		@(negedge sys_clk_i);
		outs = {irq, pu_dis, irq_b, irq_a};
		chk_word(nm, {31'h0, e}, {31'h0, outs[i]});
		@(posedge sys_clk_i);
	endtask : chk_bit

	task automatic stop_test;
		$display("Counts: errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end

	// ------------------------------------------------------------------
	// Bus tasks; entered just after a rising edge
	// ------------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic aw_ok, w_ok, aw_now, w_now, got;
		int n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		got = 1'b0;
		n = 0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 100) begin
			@(negedge sys_clk_i);
			aw_now = awvalid && awready;
			w_now = wvalid && wready;
			@(posedge sys_clk_i);
			if (aw_now) begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (w_now) begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
			n++;
		end
		while (!got && n < 200) begin
			@(negedge sys_clk_i);
			got = (bvalid === 1'b1);
			r = bresp;
			@(posedge sys_clk_i);
			n++;
		end
		bready <= 1'b0;
		@(posedge sys_clk_i);
		if (!got) err_count++;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_ok, got;
		int n;
		ar_ok = 1'b0;
		got = 1'b0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got && n < 200) begin
			@(negedge sys_clk_i);
			ar_ok = arvalid && arready;
			got = (rvalid === 1'b1) && !arvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk_i);
			if (ar_ok) arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		@(posedge sys_clk_i);
		if (!got) err_count++;
	endtask : axi_rd

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		axi_wr(a, d, rsp);
		chk_resp("bresp", RESP_OKAY, rsp);
	endtask : wreg

	task automatic rreg(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		axi_rd(a, rd_d, rsp);
		chk_resp("rresp", RESP_OKAY, rsp);
		chk_word(nm, e, rd_d);
	endtask : rreg

	// One falling edge then release, long enough for the flag to land
	task automatic pulse(input int ch);
		drv_low[ch] <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		drv_low[ch] <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask : pulse

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		brk = 1'b0;
		drv_low = 2'b00;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		// Reset contents and decode
		rreg(AD_A, 32'h0, "chan_a reset");
		rreg(AD_B, 32'h0, "chan_b reset");
		rreg(AD_BRK, 32'h0, "permit reset");
		axi_rd(AD_HOLE, rd_d, rsp);
		chk_resp("hole rresp", RESP_SLVERR, rsp);
		chk_word("hole rdata", 32'h0, rd_d);
		axi_wr(AD_HOLE, 8'hFF, rsp);
		chk_resp("hole bresp", RESP_SLVERR, rsp);
		// Falling edge, acknowledge
		pulse(0);
		rreg(AD_A, 32'h08, "a pending");
		chk_bit("irq_req_a set", 0, 1'b1);
		wreg(AD_A, 8'h04);
		rreg(AD_A, 32'h00, "a acked");
		chk_bit("irq_req_a clear", 0, 1'b0);
		// Mask blocks the request but not the flag
		wreg(AD_A, 8'h02);
		pulse(0);
		rreg(AD_A, 32'h0A, "a masked");
		chk_bit("irq_req_a masked", 0, 1'b0);
		wreg(AD_A, 8'h06);
		rreg(AD_A, 32'h02, "a ack keep mask");
		wreg(AD_A, 8'h00);
		// Held low pin: edge only, then level sense
		drv_low[1] <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rreg(AD_B, 32'h08, "b pending");
		chk_bit("irq_req_b set", 1, 1'b1);
		wreg(AD_B, 8'h04);
		rreg(AD_B, 32'h00, "b edge only");
		wreg(AD_B, 8'h05);
		rreg(AD_B, 32'h09, "b level relatch");
		chk_bit("irq_req_b level", 1, 1'b1);
		drv_low[1] <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		wreg(AD_B, 8'h04);
		rreg(AD_B, 32'h00, "b released");
		// Pullup control lives in channel B only
		wreg(AD_B, 8'h40);
		rreg(AD_B, 32'h48, "b pullup bit");
		chk_bit("pullup off", 2, 1'b1);
		wreg(AD_A, 8'h40);
		rreg(AD_A, 32'h00, "a bit6 zero");
		wreg(AD_B, 8'h04);
		chk_bit("pullup on", 2, 1'b0);
		// Acknowledge in break, without and with permit
		pulse(0);
		brk <= 1'b1;
		wreg(AD_A, 8'h04);
		rreg(AD_A, 32'h08, "break no permit");
		wreg(AD_BRK, 8'h01);
		wreg(AD_A, 8'h04);
		rreg(AD_A, 32'h00, "break permit");
		brk <= 1'b0;
		@(posedge sys_clk_i);
		rreg(AD_A, 32'h00, "after break");
		wreg(AD_BRK, 8'h00);
		// Summary interrupt: raise, mask, clear
		wreg(AD_EVS, 8'h03);
		rreg(AD_EVS, 32'h0, "events cleared");
		wreg(AD_EVM, 8'h01);
		pulse(0);
		chk_bit("irq raised", 3, 1'b1);
		rreg(AD_EVS, 32'h01, "event a");
		wreg(AD_EVM, 8'h00);
		chk_bit("irq masked", 3, 1'b0);
		wreg(AD_EVM, 8'h03);
		chk_bit("irq unmasked", 3, 1'b1);
		wreg(AD_EVS, 8'h01);
		chk_bit("irq cleared", 3, 1'b0);
		rreg(AD_EVS, 32'h0, "events empty");
		stop_test();
	end
endmodule : dual_ext_int_latch_tb_top
`default_nettype wire
